// file: isi_consts.svh
// Offsets, field positions, reset values and timing counts of the inserter
`ifndef ISI_CONSTS_SVH
`define ISI_CONSTS_SVH

// Register byte addresses
`define ISI_ADDR_FRAME_CTRL 32'hF1000610
`define ISI_ADDR_FRAME_COUNT 32'hF1000614
`define ISI_ADDR_TRIG_CTRL 32'hF1000620
`define ISI_ADDR_TRIG_COUNT 32'hF1000624
`define ISI_ADDR_SIG_CTRL 32'hF1000630
`define ISI_ADDR_SIG_USER 32'hF1000634

// Field positions
`define ISI_PRESENCE_BIT 0
`define ISI_CNT_RESET_BIT 1
`define ISI_ENABLE_BIT 6
`define ISI_LINE_LO 16
`define ISI_LINE_HI 31

// Reset values
`define ISI_ENABLE_RESET 1'b0
`define ISI_LINE_RESET 16'h0000
`define ISI_USER_RESET 32'h00000000

// Cycle time structure
`define ISI_OFS_MAX 3071
`define ISI_CYC_MAX 7999
`define ISI_OFS_RATE_KHZ 24576
`define ISI_CLK_RATE_KHZ 50000

// Signature layout, byte indices inside the line
`define ISI_SIG_BYTES 48
`define ISI_SIG_CYCLE_AT 0
`define ISI_SIG_FRAME_AT 4
`define ISI_SIG_TRIG_AT 8
`define ISI_SIG_USER_AT 44

`endif

// file: isi_pkg.sv
// Types shared by the image signature inserter
package isi_pkg;

  typedef logic [31:0] isi_word_t;

  // Bit layout gives seconds, cycles and offset their word masks
  typedef struct packed {
    logic [6:0] seconds;
    logic [12:0] cycles;
    logic [11:0] offset;
  } isi_ctime_s;

  typedef struct packed {
    logic wr;
    logic rd;
    isi_word_t addr;
    isi_word_t wdata;
  } isi_req_s;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic [7:0] data;
  } isi_pix_s;

  typedef struct packed {
    isi_ctime_s cycleTime;
    isi_word_t frameCount;
    isi_word_t trigCount;
    isi_word_t userWord;
  } isi_snap_s;

  typedef enum logic [0:0] {
    ISI_WAIT_FRAME = 1'b0,
    ISI_IN_FRAME = 1'b1
  } isi_phase_e;

  typedef struct packed {
    isi_phase_e phase;
    logic [1:0] integSync;
    logic [1:0] trigSync;
    logic integPrev;
    logic trigPrev;
    logic [15:0] phaseAcc;
    isi_ctime_s cycleTime;
    isi_ctime_s cycleLatch;
    isi_word_t frameCount;
    isi_word_t trigCount;
    logic sigEnable;
    logic [15:0] lineField;
    isi_word_t userWord;
    isi_snap_s snap;
    logic [15:0] lineCnt;
    logic [15:0] byteCnt;
    isi_word_t rdata;
    isi_pix_s pix;
  } isi_state_s;

endpackage

// file: isi_user_mem.sv
// Per-entry user words for sequence mode, registered read port
`timescale 1ns/1ps
module isi_user_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input isi_pkg::isi_word_t wrData,
  input wire logic [AW-1:0] rdAddr,
  output isi_pkg::isi_word_t rdData
);
  import isi_pkg::*;

  isi_word_t mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Array itself has no reset; entries read as written
  // Write-first, so a read just after a write sees the new word
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData <= '0;
    end else begin
      rdData <= (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
    end
  end
endmodule // isi_user_mem

// file: isi_inserter.sv
// Image signature inserter: counters, cycle timer, registers, stream path
//
// Notes on behaviour
// - Control bit 0 reads as feature present
// - Enable bit 6 gates signature insertion
// - Target line from control bits 16..31
// - Non-negative position counts from the top
// - Negative position counts from the bottom
// - Position equal height hits padding line
// - No padding: signature is simply omitted
// - Writable 32-bit user word enters signature
// - Sequence mode uses per-entry user word
// - Cycle time latched at integration start
// - Cycle time fills the first four bytes
// - Offset counts 0..3071 at 24.576 MHz
// - Cycles 0..7999 carry into seconds 0..127
// - Seconds, cycles, offset packed per masks
// - Multi-byte values go out low byte first
// - Frame and trigger counters in signature
// - Both counters readable through own registers
// - Counters inserted as full 32-bit values
// - Reset request clears counter, self-clears
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "isi_consts.svh"
module isi_inserter #(
  parameter int SEQ_DEPTH = 32,
  parameter int SEQ_AW = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input isi_pkg::isi_req_s regReq,
  output isi_pkg::isi_word_t regRdata,
  input isi_pkg::isi_pix_s pixIn,
  output isi_pkg::isi_pix_s pixOut,
  input wire logic integStartPin,
  input wire logic extTriggerPin,
  input wire logic [15:0] imageHeightLines,
  input wire logic framePadding,
  input wire logic seqModeOn,
  input wire logic [SEQ_AW-1:0] seqEntry
);
  import isi_pkg::*;

  logic [1:0] rstPipe;
  logic rstN;
  isi_state_s s;
  isi_state_s next_s;
  isi_word_t seqUserWord;
  logic seqWrite;

  // Advance the nested cycle timer by one offset tick
  function automatic isi_ctime_s ctimeTick(input isi_ctime_s c);
    isi_ctime_s r;
    r = c;
    if (c.offset == 12'(`ISI_OFS_MAX)) begin
      r.offset = 12'h000;
      if (c.cycles == 13'(`ISI_CYC_MAX)) begin
        r.cycles = 13'h0000;
        r.seconds = 7'(c.seconds + 7'h01);
      end else begin
        r.cycles = 13'(c.cycles + 13'h0001);
      end
    end else begin
      r.offset = 12'(c.offset + 12'h001);
    end
    return r;
  endfunction

  // Byte i of a word, lowest byte first
  function automatic logic [7:0] wordByte(input isi_word_t w,
                                          input logic [1:0] i);
    return w[8*i +: 8];
  endfunction

  // Signature byte at a given position of the signature line
  function automatic logic [7:0] sigByte(input isi_snap_s sn,
                                         input logic [15:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx < 16'(`ISI_SIG_FRAME_AT)) begin
      b = wordByte(sn.cycleTime, idx[1:0]);
    end else if (idx < 16'(`ISI_SIG_TRIG_AT)) begin
      b = wordByte(sn.frameCount, idx[1:0]);
    end else if (idx < 16'(`ISI_SIG_TRIG_AT + 4)) begin
      b = wordByte(sn.trigCount, idx[1:0]);
    end else if (idx >= 16'(`ISI_SIG_USER_AT) &&
                 idx < 16'(`ISI_SIG_BYTES)) begin
      b = wordByte(sn.userWord, idx[1:0]);
    end
    return b;
  endfunction

  // Counter register view: presence bit only, reset bit reads zero
  function automatic isi_word_t ctrlView();
    isi_word_t v;
    v = '0;
    v[`ISI_PRESENCE_BIT] = 1'b1;
    return v;
  endfunction

  // Control register readback: presence, enable and signed position
  function automatic isi_word_t ctrlWord(input logic en,
                                         input logic [15:0] pos);
    isi_word_t v;
    v = '0;
    v[`ISI_PRESENCE_BIT] = 1'b1;
    v[`ISI_ENABLE_BIT] = en;
    v[`ISI_LINE_HI:`ISI_LINE_LO] = pos;
    return v;
  endfunction

  // Write strobe aimed at one register address
  function automatic logic wrHit(input isi_req_s q, input isi_word_t a);
    return q.wr && q.addr == a;
  endfunction

  // Rising edge between the synchronised level and its previous sample
  function automatic logic rise(input logic cur, input logic prev);
    return cur && !prev;
  endfunction

  // Next counter value; a clear meeting an event keeps the event
  function automatic isi_word_t cntNext(input isi_word_t c,
                                        input logic clr,
                                        input logic ev);
    isi_word_t r;
    r = c;
    if (clr) begin
      r = ev ? 32'h00000001 : 32'h00000000;
    end else if (ev) begin
      r = 32'(c + 32'h00000001);
    end
    return r;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // Sequence mode steers user word writes to the active entry
  assign seqWrite = wrHit(regReq, `ISI_ADDR_SIG_USER) && seqModeOn;

  isi_user_mem #(
    .DEPTH(SEQ_DEPTH),
    .AW(SEQ_AW)
  ) userMem (
    .clk(clk),
    .rstN(rstN),
    .wrEn(seqWrite),
    .wrAddr(seqEntry),
    .wrData(regReq.wdata),
    .rdAddr(seqEntry),
    .rdData(seqUserWord)
  );

  logic [16:0] accSum;
  logic integEdge;
  logic trigEdge;
  logic frameReset;
  logic trigReset;
  logic signed [16:0] posSigned;
  logic signed [16:0] heightSigned;
  logic signed [16:0] tgtSigned;
  logic tgtValid;
  logic [15:0] tgtLine;
  logic [15:0] curLine;
  logic [15:0] curByte;
  isi_snap_s liveSnap;
  isi_snap_s useSnap;
  logic inFrame;
  logic doInsert;
  isi_word_t activeUser;
  isi_word_t ctrlRead;

  always_comb begin
    next_s = s;

    // Pins from outside pass two flops before any use
    next_s.integSync = {s.integSync[0], integStartPin};
    next_s.trigSync = {s.trigSync[0], extTriggerPin};
    next_s.integPrev = s.integSync[1];
    next_s.trigPrev = s.trigSync[1];
    integEdge = rise(s.integSync[1], s.integPrev);
    trigEdge = rise(s.trigSync[1], s.trigPrev);

    // Offset ticks at 24.576 MHz from a 50 MHz clock by phase stepping
    accSum = {1'b0, s.phaseAcc} + 17'(`ISI_OFS_RATE_KHZ);
    if (accSum >= 17'(`ISI_CLK_RATE_KHZ)) begin
      next_s.phaseAcc = 16'(accSum - 17'(`ISI_CLK_RATE_KHZ));
      next_s.cycleTime = ctimeTick(s.cycleTime);
    end else begin
      next_s.phaseAcc = accSum[15:0];
    end

    if (integEdge) begin
      next_s.cycleLatch = s.cycleTime;
    end

    // Sequence mode takes the active entry's word
    // Entry change shows one cycle late, the memory read is registered
    activeUser = seqModeOn ? seqUserWord : s.userWord;

    // Stream position of the incoming byte
    if (pixIn.sof) begin
      curLine = 16'h0000;
    end else if (pixIn.sol) begin
      curLine = 16'(s.lineCnt + 16'h0001);
    end else begin
      curLine = s.lineCnt;
    end
    curByte = (pixIn.sof || pixIn.sol) ? 16'h0000 : s.byteCnt;

    // Snapshot taken at frame start, held for the whole frame
    liveSnap.cycleTime = s.cycleLatch;
    liveSnap.frameCount = s.frameCount;
    liveSnap.trigCount = s.trigCount;
    liveSnap.userWord = activeUser;
    useSnap = pixIn.sof ? liveSnap : s.snap;

    // Target line from the signed position field
    // Positions below minus the height select no line at all
    posSigned = 17'(signed'(s.lineField));
    heightSigned = signed'({1'b0, imageHeightLines});
    if (posSigned >= 0) begin
      tgtSigned = posSigned;
    end else begin
      tgtSigned = heightSigned + posSigned;
    end
    if (posSigned < -heightSigned) begin
      tgtValid = 1'b0;
    end else if (tgtSigned < heightSigned) begin
      tgtValid = 1'b1;
    end else if (tgtSigned == heightSigned) begin
      tgtValid = framePadding;
    end else begin
      tgtValid = 1'b0;
    end
    tgtLine = tgtSigned[15:0];

    inFrame = pixIn.sof || s.phase == ISI_IN_FRAME;
    doInsert = pixIn.valid && inFrame && s.sigEnable &&
               tgtValid && curLine == tgtLine &&
               curByte < 16'(`ISI_SIG_BYTES);

    // Signature overwrites bytes in place; framing is untouched
    next_s.pix = pixIn;
    if (doInsert) begin
      next_s.pix.data = sigByte(useSnap, curByte);
    end

    // Insertion waits for the first frame start after reset
    unique case (s.phase)
      ISI_WAIT_FRAME: begin
        if (pixIn.valid && pixIn.sof) begin
          next_s.phase = ISI_IN_FRAME;
        end
      end
      ISI_IN_FRAME: begin
        next_s.phase = ISI_IN_FRAME;
      end
    endcase

    if (pixIn.valid) begin
      next_s.lineCnt = curLine;
      // Byte count saturates so an endless line never wraps to a match
      if (curByte != 16'hFFFF) begin
        next_s.byteCnt = 16'(curByte + 16'h0001);
      end else begin
        next_s.byteCnt = curByte;
      end
      if (pixIn.sof) begin
        next_s.snap = liveSnap;
      end
    end

    // Counter reset requests; a coincident event still counts
    frameReset = wrHit(regReq, `ISI_ADDR_FRAME_CTRL) &&
                 regReq.wdata[`ISI_CNT_RESET_BIT];
    trigReset = wrHit(regReq, `ISI_ADDR_TRIG_CTRL) &&
                regReq.wdata[`ISI_CNT_RESET_BIT];
    next_s.frameCount = cntNext(s.frameCount, frameReset,
                                pixIn.valid && pixIn.sof);
    next_s.trigCount = cntNext(s.trigCount, trigReset, trigEdge);

    // Register writes
    // Enable and position act at once, even in mid-frame
    if (regReq.wr) begin
      unique case (regReq.addr)
        `ISI_ADDR_SIG_CTRL: begin
          next_s.sigEnable = regReq.wdata[`ISI_ENABLE_BIT];
          next_s.lineField =
            regReq.wdata[`ISI_LINE_HI:`ISI_LINE_LO];
        end
        `ISI_ADDR_SIG_USER: begin
          if (!seqModeOn) begin
            next_s.userWord = regReq.wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data in the following cycle
    ctrlRead = ctrlWord(s.sigEnable, s.lineField);
    next_s.rdata = '0;
    if (regReq.rd) begin
      unique case (regReq.addr)
        `ISI_ADDR_SIG_CTRL: next_s.rdata = ctrlRead;
        `ISI_ADDR_SIG_USER: next_s.rdata = activeUser;
        `ISI_ADDR_FRAME_CTRL: next_s.rdata = ctrlView();
        `ISI_ADDR_TRIG_CTRL: next_s.rdata = ctrlView();
        `ISI_ADDR_FRAME_COUNT: next_s.rdata = s.frameCount;
        `ISI_ADDR_TRIG_COUNT: next_s.rdata = s.trigCount;
        default: next_s.rdata = '0;
      endcase
    end
  end

  // Whole state in one register; reset values from the constants header
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
      s.phase <= ISI_WAIT_FRAME;
      s.sigEnable <= `ISI_ENABLE_RESET;
      s.lineField <= `ISI_LINE_RESET;
      s.userWord <= `ISI_USER_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign regRdata = s.rdata;
  assign pixOut = s.pix;
endmodule // isi_inserter

// file: isi_inserter_asserts.sv
// Port checker for the image signature inserter
`timescale 1ns/1ps
`include "isi_consts.svh"
module isi_inserter_asserts #(
  parameter int SEQ_DEPTH = 32,
  parameter int SEQ_AW = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input isi_pkg::isi_req_s regReq,
  input isi_pkg::isi_word_t regRdata,
  input isi_pkg::isi_pix_s pixIn,
  input isi_pkg::isi_pix_s pixOut,
  input wire logic integStartPin,
  input wire logic extTriggerPin,
  input wire logic [15:0] imageHeightLines,
  input wire logic framePadding,
  input wire logic seqModeOn,
  input wire logic [SEQ_AW-1:0] seqEntry
);
  import isi_pkg::*;
  logic enShadow;
  logic [15:0] lineShadow;
  isi_word_t userShadow;
  isi_word_t sofCnt;
  logic wrCtrl;
  logic sofIn;
  assign wrCtrl = regReq.wr && regReq.addr == `ISI_ADDR_SIG_CTRL;
  assign sofIn = pixIn.valid && pixIn.sof;
  // Shadows follow the live register writes; user word only outside seq mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enShadow <= 1'b0;
      lineShadow <= 16'h0000;
      userShadow <= 32'h00000000;
      sofCnt <= 32'h00000000;
    end else begin
      if (wrCtrl) begin
        enShadow <= regReq.wdata[6];
        lineShadow <= regReq.wdata[31:16];
      end
      if (regReq.wr && regReq.addr == `ISI_ADDR_SIG_USER && !seqModeOn)
        userShadow <= regReq.wdata;
      if (regReq.wr && regReq.addr == `ISI_ADDR_FRAME_CTRL && regReq.wdata[1])
        sofCnt <= 32'(sofIn);
      else if (sofIn)
        sofCnt <= sofCnt + 32'h00000001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_framing_follows: assert property (##1 pixOut.valid == $past(pixIn.valid)
    && pixOut.sof == $past(pixIn.sof) && pixOut.sol == $past(pixIn.sol))
    else $error("framing not passed through");
  a_pass_when_off: assert property (
    pixIn.valid && !enShadow |=> pixOut.data == $past(pixIn.data))
    else $error("byte changed while disabled");
  a_rdata_idle: assert property (!$past(regReq.rd) |-> regRdata == '0)
    else $error("read data outside read slot");
  a_presence_bit: assert property (
    regReq.rd && regReq.addr == `ISI_ADDR_SIG_CTRL |=> regRdata[0])
    else $error("presence bit low");
  a_ctrl_readback: assert property (
    regReq.rd && regReq.addr == `ISI_ADDR_SIG_CTRL
    |=> regRdata[6] == enShadow && regRdata[31:16] == lineShadow)
    else $error("control readback wrong");
  a_user_readback: assert property (
    regReq.rd && regReq.addr == `ISI_ADDR_SIG_USER && !seqModeOn
    |=> regRdata == userShadow)
    else $error("user word readback wrong");
  a_frame_read: assert property (
    regReq.rd && regReq.addr == `ISI_ADDR_FRAME_COUNT
    |=> regRdata == $past(sofCnt))
    else $error("frame counter readback wrong");
  a_reset_selfclr: assert property (
    regReq.rd && regReq.addr == `ISI_ADDR_FRAME_CTRL
    |=> regRdata[1:0] == 2'h1)
    else $error("frame control readback wrong");
endmodule // isi_inserter_asserts

bind isi_inserter isi_inserter_asserts #(.SEQ_DEPTH(SEQ_DEPTH),
  .SEQ_AW(SEQ_AW)) u_chk (.clk(clk), .reset_n(reset_n), .regReq(regReq),
  .regRdata(regRdata), .pixIn(pixIn), .pixOut(pixOut),
  .integStartPin(integStartPin), .extTriggerPin(extTriggerPin),
  .imageHeightLines(imageHeightLines), .framePadding(framePadding),
  .seqModeOn(seqModeOn), .seqEntry(seqEntry));

// file: isi_host_model.sv
// Host software model issuing register reads and writes
`timescale 1ns/1ps
module isi_host_model (
  input wire logic clk,
  output isi_pkg::isi_req_s regReq,
  input isi_pkg::isi_word_t regRdata
);
  import isi_pkg::*;
  initial regReq = '0;
  // Trailing idle edge keeps two strobes from landing in one time step
  task automatic wr(input isi_word_t a, input isi_word_t d);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    regReq <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input isi_word_t a, output isi_word_t d);
    regReq <= '{1'b0, 1'b1, a, 32'h00000000};
    @(posedge clk);
    regReq <= '0;
    #1 d = regRdata;
    @(posedge clk);
  endtask
endmodule // isi_host_model

// file: image_signature_inserter_test.sv
// Testbench for the image signature inserter
`timescale 1ns/1ps
`include "isi_consts.svh"
module image_signature_inserter_test;
  import isi_pkg::*;
  localparam int H = 4;
  localparam int LEN = 52;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  isi_req_s regReq;
  isi_word_t regRdata, rv, ue;
  isi_pix_s pixIn = '0, pixOut;
  logic integ = 1'b0, trig = 1'b0, pad = 1'b0, seqOn = 1'b0;
  // Until the first integration start the latched cycle time is zero
  logic ctKnown = 1'b1;
  logic [4:0] seqEntry = 5'h00;
  int nErrors = 0, numChecks = 0, nFrm = 0, nTrg = 0, cyc = 0;
  logic [7:0] got[$];
  isi_ctime_s ct;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  isi_inserter u_dut (.clk(clk), .reset_n(reset_n), .regReq(regReq),
    .regRdata(regRdata), .pixIn(pixIn), .pixOut(pixOut),
    .integStartPin(integ), .extTriggerPin(trig),
    .imageHeightLines(16'(H)), .framePadding(pad), .seqModeOn(seqOn),
    .seqEntry(seqEntry));
  isi_host_model u_host (.clk(clk), .regReq(regReq), .regRdata(regRdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Output of byte i is read one edge later, after that edge has landed
  task automatic send_frame(input int nl);
    got.delete();
    for (int i = 0; i <= nl * LEN; i++) begin
      @(posedge clk);
      if (i < nl * LEN)
        pixIn <= '{1'b1, i == 0, i % LEN == 0 && i > 0, 8'h80 | 8'(i)};
      else
        pixIn <= '0;
      #1 if (i > 0 && pixOut.valid === 1'b1) got.push_back(pixOut.data);
    end
    @(posedge clk);
  endtask
  task automatic check_frame(input int t, input int nl);
    logic [383:0] sig;
    check(got.size(), nl * LEN);
    if (t >= 0 && !ctKnown)
      ct = {got[t*LEN+3], got[t*LEN+2], got[t*LEN+1], got[t*LEN]};
    sig = {ue, 256'h0, 32'(nTrg), 32'(nFrm), ct};
    for (int i = 0; i < nl * LEN; i++)
      check(got[i], (i / LEN == t && i % LEN < 48) ?
        sig[8*(i%LEN) +: 8] : 8'h80 | 8'(i));
    if (t >= 0) check(ct.offset <= 3071 && ct.cycles <= 7999, 1);
    nFrm++;
  endtask
  task automatic run_pos(input logic en, input logic [15:0] p,
                         input logic pd, input int t);
    u_host.wr(`ISI_ADDR_SIG_CTRL, {p, 9'h000, en, 6'h00});
    pad <= pd;
    send_frame(H + pd);
    check_frame(t, H + pd);
  endtask
  task automatic integ_pulse();
    ctKnown = 1'b0;
    integ <= 1'b1;
    repeat (3) @(posedge clk);
    integ <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reg_map();
    u_host.rd(`ISI_ADDR_SIG_USER, rv);
    check(rv, 32'h00000000);
    u_host.wr(`ISI_ADDR_SIG_CTRL, 32'hFFFB0040);
    u_host.rd(`ISI_ADDR_SIG_CTRL, rv);
    check(rv & 32'hFFFF0041, 32'hFFFB0041);
    ue = 32'hC0DE1234;
    u_host.wr(`ISI_ADDR_SIG_USER, ue);
    u_host.rd(`ISI_ADDR_SIG_USER, rv);
    check(rv, ue);
    u_host.rd(32'hF1000638, rv);
    check(rv, 32'h00000000);
    $display("test reg_map done");
  endtask
  task automatic t_counters();
    repeat (3) begin
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
    end
    nTrg = 3;
    run_pos(1'b1, 16'h0000, 1'b0, 0);
    run_pos(1'b1, 16'h0000, 1'b0, 0);
    u_host.rd(`ISI_ADDR_FRAME_COUNT, rv);
    check(rv, 32'h00000002);
    u_host.rd(`ISI_ADDR_TRIG_COUNT, rv);
    check(rv, 32'h00000003);
    u_host.wr(`ISI_ADDR_FRAME_CTRL, 32'h00000002);
    u_host.wr(`ISI_ADDR_TRIG_CTRL, 32'h00000002);
    u_host.rd(`ISI_ADDR_TRIG_CTRL, rv);
    check(rv[1:0], 2'b01);
    u_host.rd(`ISI_ADDR_FRAME_CTRL, rv);
    check(rv[1:0], 2'h1);
    nFrm = 0;
    nTrg = 0;
    u_host.rd(`ISI_ADDR_FRAME_COUNT, rv);
    check(rv, 32'h00000000);
    run_pos(1'b1, 16'h0000, 1'b0, 0);
    $display("test counters done");
  endtask
  task automatic t_positions();
    run_pos(1'b0, 16'h0000, 1'b0, -1);
    run_pos(1'b1, 16'h0002, 1'b0, 2);
    run_pos(1'b1, 16'hFFFF, 1'b0, H - 1);
    run_pos(1'b1, 16'hFFFC, 1'b0, 0);
    run_pos(1'b1, 16'hFFFB, 1'b0, -1);
    run_pos(1'b1, 16'h0004, 1'b1, H);
    run_pos(1'b1, 16'h0004, 1'b0, -1);
    $display("test positions done");
  endtask
  task automatic t_cycle_time();
    isi_ctime_s a;
    int c1, c2, d, e;
    c1 = cyc;
    integ_pulse();
    run_pos(1'b1, 16'h0001, 1'b0, 1);
    a = ct;
    run_pos(1'b1, 16'h0001, 1'b0, 1);
    check(ct, a);
    repeat (7000) @(posedge clk);
    c2 = cyc;
    integ_pulse();
    run_pos(1'b1, 16'h0001, 1'b0, 1);
    d = (ct.cycles * 3072 + ct.offset) - (a.cycles * 3072 + a.offset);
    e = (c2 - c1) * 24576 / 50000;
    check(d >= e - 2 && d <= e + 2, 1);
    $display("test cycle_time done");
  endtask
  task automatic t_seq_user();
    seqOn <= 1'b1;
    seqEntry <= 5'h03;
    u_host.wr(`ISI_ADDR_SIG_USER, 32'hA5A50003);
    seqEntry <= 5'h04;
    u_host.wr(`ISI_ADDR_SIG_USER, 32'h5A5A0004);
    seqEntry <= 5'h03;
    ue = 32'hA5A50003;
    run_pos(1'b1, 16'h0000, 1'b0, 0);
    seqEntry <= 5'h04;
    ue = 32'h5A5A0004;
    run_pos(1'b1, 16'h0000, 1'b0, 0);
    u_host.rd(`ISI_ADDR_SIG_USER, rv);
    check(rv, 32'h5A5A0004);
    $display("test seq_user done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reg_map();
    t_counters();
    t_positions();
    t_cycle_time();
    t_seq_user();
    tally_and_finish();
  end
  // Run needs about 10300 cycles; limit allows about 50000
  initial begin
    #1000000;
    nErrors++;
    tally_and_finish();
  end
endmodule // image_signature_inserter_test
